/* File: bench/plcfg_assertions.sv */
/*
  Port-level checker for the configuration register bank.
  Assumes zero-wait AHB-Lite, data phase one cycle after address phase.
*/
`timescale 1ns/1ps
module plcfg_assertions (
  input wire logic                       hclk,
  input wire logic                       hresetn,
  input wire logic                       hsel,
  input wire logic [31:0]                haddr,
  input wire logic [1:0]                 htrans,
  input wire logic                       hwrite,
  input wire logic                       hready,
  input wire logic [31:0]                hwdata,
  input wire logic [31:0]                hrdata,
  input wire plcfg_pkg::plcfg_phy_ctrl_t phy_ctrl,
  input wire logic                       irq_or_powerdown_pin_oe,
  input wire logic                       powerdown_request,
  input wire logic                       cable_diag_run,
  input wire logic                       cable_diag_complete
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////////////////////////////////////////
  logic        wr_q;
  logic        wr2_q;
  logic        rd_q;
  logic [9:0]  ra_q;
  logic [31:0] d_q;
  // Write data phase to general config, then the cycle after it lands
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q  <= 1'b0;
      wr2_q <= 1'b0;
      rd_q  <= 1'b0;
      ra_q  <= 10'h000;
      d_q   <= 32'h0000_0000;
    end else begin
      wr_q  <= hsel && hready && htrans[1] && hwrite && (haddr[9:0] == 10'h078);
      wr2_q <= wr_q;
      rd_q  <= hsel && hready && htrans[1] && !hwrite;
      ra_q  <= haddr[9:0];
      d_q   <= hwdata;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  a_pin_role_excl: assert property (!(irq_or_powerdown_pin_oe && powerdown_request))
    else $error("pin driven while powerdown requested");
  a_diag_run_drop: assert property (cable_diag_run && cable_diag_complete |=> !cable_diag_run)
    else $error("diag run not cleared on completion");
  a_diag_run_rise: assert property ($rose(cable_diag_run) |-> wr2_q && d_q[0])
    else $error("diag run rose without a start write");
  a_clear_pulse: assert property (phy_ctrl.clear_status_pulse |-> wr2_q && d_q[10])
    else $error("status clear without a write of bit 10");
  a_quick_x_fol: assert property (wr_q |=> phy_ctrl.quick_crossover_enable == d_q[8])
    else $error("quick crossover does not follow bit 8");
  a_quick_neg_fol: assert property (wr_q |=> {phy_ctrl.quick_negotiation_enable,
    phy_ctrl.quick_negotiation_timer_select} == d_q[14:12])
    else $error("quick negotiation fields do not follow");
  a_misc_cfg_hold: assert property ($changed({phy_ctrl.parallel_detect_full_duplex_enable,
    phy_ctrl.robust_crossover_enable, phy_ctrl.gigabit_only_negotiation_enable}) |-> wr2_q)
    else $error("config output changed without a write");
  a_reserved_zero: assert property (rd_q && (ra_q == 10'h064 || ra_q == 10'h068) |->
    (hrdata & ((ra_q == 10'h064) ? 32'hffff_8888 : 32'hffff_fff8)) == 32'h0000_0000)
    else $error("reserved bits read nonzero");
endmodule // plcfg_assertions
bind plcfg_top plcfg_assertions i_plcfg_assertions (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hready, .hwdata, .hrdata, .phy_ctrl, .irq_or_powerdown_pin_oe, .powerdown_request, .cable_diag_run,
  .cable_diag_complete);

/* File: bench/plcfg_diag_model.sv */
/*
  Cable diagnostic engine model standing beside the register bank.
  Assumes run comes from the bank start bit, synchronous to hclk.
*/
`timescale 1ns/1ps
module plcfg_diag_model #(
  parameter int LAT = 30
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic run,
  input  wire logic fail_sel,
  output logic      complete,
  output logic      result_fail
);
  int cnt_q;
  // One pulse per run; result toggles outside it so it is never stale
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q       <= 0;
      complete    <= 1'b0;
      result_fail <= 1'b0;
    end else begin
      cnt_q       <= (run && !complete) ? cnt_q + 1 : 0;
      complete    <= run && (cnt_q == LAT - 1);
      result_fail <= (run && (cnt_q == LAT - 1)) ? fail_sel : ~result_fail;
    end
  end
endmodule // plcfg_diag_model

/* File: bench/plcfg_top_bench.sv */
/*
  Self-checking bench for the configuration register bank.
  Assumes BLINK_UNIT of 1, so blink periods are 50..500 cycles.
*/
`timescale 1ns/1ps
module plcfg_top_bench;
  logic hclk, hresetn, hsel, hwrite, irq_event, pd_drv, diag_fail, cpl, cfail;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, pin_o, pin_oe, pdreq, run;
  logic [3:0] ind;
  plcfg_pkg::plcfg_phy_status_t ps;
  plcfg_pkg::plcfg_phy_ctrl_t pc;
  int errors, checks;
  wire hready = hreadyout;
  wire pin = pin_oe ? 1'b0 : pd_drv; // Open drain wire level
  plcfg_top #(.BLINK_UNIT(1)) i_plcfg_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hrdata, .hreadyout, .hresp, .phy_status(ps), .phy_ctrl(pc), .irq_event,
    .irq_or_powerdown_pin_i(pin), .irq_or_powerdown_pin_o(pin_o), .irq_or_powerdown_pin_oe(pin_oe),
    .powerdown_request(pdreq), .cable_diag_complete(cpl), .cable_diag_result_fail(cfail),
    .cable_diag_run(run), .indicator_out(ind));
  plcfg_diag_model #(.LAT(30)) i_plcfg_diag_model (.hclk, .hresetn, .run, .fail_sel(diag_fail),
    .complete(cpl), .result_fail(cfail));
  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1; haddr <= a; htrans <= 2'b10; hwrite <= w; hsize <= 3'b010;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rchk(input string n, input logic [31:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    chk(n, rd, exp);
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge hclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rchk("ind_ctrl", 32'h64, 32'h4444);
    rchk("blink", 32'h68, 32'h0002);
    rchk("gen_cfg", 32'h78, 32'h0012);
    rchk("unmapped", 32'h7c, 32'h0);
    chk("hresp", hresp, 1'b0);
    chk("ind_rst", ind, 4'h0);
  endtask
  task automatic t_reserved;
    xfer(32'h64, 1'b1, 32'hffff_ffff);
    rchk("ind_rsv", 32'h64, 32'h7777);
    xfer(32'h68, 1'b1, 32'hffff_ffff);
    rchk("blink_rsv", 32'h68, 32'h0007);
    xfer(32'h68, 1'b1, 32'h2);
  endtask
  task automatic t_force;
    logic [3:0] code [5] = '{4'h7, 4'h1, 4'h5, 4'h6, 4'h0};
    logic pin_exp [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
    for (int i = 0; i < 4; i++) begin
      for (int k = 0; k < 5; k++) begin
        xfer(32'h64, 1'b1, (32'h4444 & ~(32'hf << (4 * i))) | (32'(code[k]) << (4 * i)));
        wait_n(3);
        chk("ind_force", ind, 4'(pin_exp[k]) << i);
      end
    end
    xfer(32'h64, 1'b1, 32'h4444);
  endtask
  task automatic t_stretch;
    int p [4] = '{plcfg_pkg::BLINK_MS_0, plcfg_pkg::BLINK_MS_1, plcfg_pkg::BLINK_MS_2, plcfg_pkg::BLINK_MS_3};
    for (int r = 0; r < 4; r++) begin
      xfer(32'h68, 1'b1, 32'(r));
      ps.link_ok <= 1'b1;
      wait_n(1100);
      chk("ind_link", ind[0], 1'b1);
      ps.link_ok <= 1'b0;
      wait_n(p[r] - 2);
      chk("ind_held", ind[0], 1'b1);
      wait_n(p[r] + 7);
      chk("ind_off", ind[0], 1'b0);
    end
    xfer(32'h68, 1'b1, 32'h6);
    ps.link_ok <= 1'b1;
    wait_n(5);
    ps.link_ok <= 1'b0;
    ps.tx_act <= 1'b1;
    ps.link_100 <= 1'b1;
    wait_n(4);
    chk("ind_src", ind, 4'he);
    ps.tx_act <= 1'b0;
    ps.link_100 <= 1'b0;
    wait_n(4);
    chk("ind_bypass", ind, 4'h0);
    xfer(32'h68, 1'b1, 32'h2);
  endtask
  task automatic t_gen;
    xfer(32'h78, 1'b1, 32'h7f18);
    wait_n(1);
    chk("clr_pulse", pc.clear_status_pulse, 1'b1);
    wait_n(1);
    chk("clr_once", pc.clear_status_pulse, 1'b0);
    rchk("gen_rw", 32'h78, 32'h7f1a);
    chk("ctrl_on", {pc[7:4], pc[2:0]}, 7'h7f);
    xfer(32'h78, 1'b1, 32'h10);
    wait_n(2);
    chk("ctrl_off", {pc[7:4], pc[2:0]}, 7'h00);
  endtask
  task automatic t_irq;
    irq_event <= 1'b1; pd_drv <= 1'b0;
    wait_n(3);
    chk("pd_in", {pdreq, pin_oe}, 2'b10);
    pd_drv <= 1'b1;
    xfer(32'h78, 1'b1, 32'h90);
    wait_n(3);
    chk("irq_out", {pdreq, pin_oe}, 2'b01);
    irq_event <= 1'b0;
    wait_n(3);
    chk("irq_idle", pin_oe, 1'b0);
    xfer(32'h78, 1'b1, 32'hd0);
    wait_n(3);
    chk("irq_force", {pdreq, pin_oe}, 2'b01);
    chk("pin_low", pin_o, 1'b0);
    xfer(32'h78, 1'b1, 32'h10);
  endtask
  task automatic t_diag;
    for (int f = 1; f >= 0; f--) begin
      diag_fail <= f[0];
      xfer(32'h78, 1'b1, 32'h11);
      rchk("diag_busy", 32'h78, 32'h11);
      chk("diag_run", run, 1'b1);
      wait_n(40);
      rchk("diag_done", 32'h78, 32'h12 | (32'(f) << 2));
      chk("diag_end", run, 1'b0);
    end
    xfer(32'h78, 1'b1, 32'h14);
    rchk("diag_ro", 32'h78, 32'h12);
    chk("diag_idle", run, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  initial begin
    #(20ns * 40000);
    errors++;
    summarize();
  end
  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'b00; hwrite = 1'b0; hsize = 3'b010;
    hwdata = '0; ps = '0; irq_event = 1'b0; pd_drv = 1'b1; diag_fail = 1'b0; errors = 0; checks = 0;
    wait_n(12);
    hresetn <= 1'b1;
    t_reset();
    t_reserved();
    t_force();
    t_stretch();
    t_gen();
    t_irq();
    t_diag();
    summarize();
  end
endmodule // plcfg_top_bench

/* File: src/plcfg_pkg.sv */
/*
  Package for the indicator and general configuration register bank:
  register offsets, field positions, reset values, timing constants and the
  packed carriers.
  Assumes a 50 MHz core clock and word-aligned AHB-Lite access.
*/
// Functional notes
// - Bit 14 sets aux indicator polarity, default high
// - Bit 12 forces aux indicator to bit 13
// - Bit 10 sets indicator 2 polarity, default high
// - Bit 8 forces indicator 2 to bit 9
// - Bit 6 sets indicator 1 polarity, default high
// - Bit 4 forces indicator 1 to bit 5
// - Bit 2 sets indicator 0 polarity, default high
// - Bit 0 forces indicator 0 to bit 1
// - Blink rate field picks 50/100/200/500 ms period
// - Blink bit 2 bypasses indicator pulse stretching
// - Bit 14 enables quick negotiation timers
// - Bits 13:12 choose shortened timer length
// - Bit 11 declares full duplex on parallel detect
// - Bit 10 clears physical status bits
// - Bit 9 robust crossover, bit 8 quick crossover
// - Quick crossover applied only while bit 8 set
// - Bit 7: shared pin interrupt out or power-down in
// - Bit 6 forces interrupt pin asserted
// - Bit 3 invokes gigabit-only negotiation for manual gigabit
// - Start bit self-clears on done; done/fail read-only
// - Normal indicator shows its selected source condition
package plcfg_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices and byte addresses
  localparam logic [7:0]  IND_CTRL_IDX   = 8'h19;
  localparam logic [7:0]  BLINK_CFG_IDX  = 8'h1a;
  localparam logic [7:0]  GENERAL_CONFIG_FOUR_IDX   = 8'h1e;
  localparam logic [7:0]  SRC_SEL_IDX    = 8'h18;
  localparam int          ADDR_W         = 10;

  localparam logic [15:0] IND_CTRL_RST   = 16'h4444;
  localparam logic [15:0] BLINK_CFG_RST  = 16'h0002;
  localparam logic [15:0] GENERAL_CONFIG_FOUR_RST   = 16'h0012;
  localparam logic [15:0] SRC_SEL_RST    = 16'h6210;

  // Writable masks; reserved bits of the indicator and blink registers drop
  localparam logic [15:0] IND_CTRL_WMASK  = 16'h7777;
  localparam logic [15:0] BLINK_CFG_WMASK = 16'h0007;
  localparam logic [15:0] GENERAL_CONFIG_FOUR_WMASK  = 16'hfff8;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int IND_FIELD_W      = 4;
  localparam int IND_POL_OFS      = 2;
  localparam int IND_VAL_OFS      = 1;
  localparam int IND_EN_OFS       = 0;
  localparam int NUM_IND          = 4;
  localparam int BLK_BYPASS_BIT   = 2;
  localparam int GC_QNEG_EN_BIT   = 14;
  localparam int GC_QNEG_SEL_LSB  = 12;
  localparam int GC_PD_FD_BIT     = 11;
  localparam int GC_CLR_STAT_BIT  = 10;
  localparam int GC_ROBUST_X_BIT  = 9;
  localparam int GC_QUICK_X_BIT   = 8;
  localparam int GC_INT_OE_BIT    = 7;
  localparam int GC_FORCE_INT_BIT = 6;
  localparam int GC_GIG_NEG_BIT   = 3;
  localparam int GC_FAIL_BIT      = 2;
  localparam int GC_DONE_BIT      = 1;
  localparam int GC_START_BIT     = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Blink timing
  localparam int          CLK_HZ       = 50_000_000;
  localparam int          BLINK_MS_0   = 50;
  localparam int          BLINK_MS_1   = 100;
  localparam int          BLINK_MS_2   = 200;
  localparam int          BLINK_MS_3   = 500;
  localparam int          CYC_PER_MS   = CLK_HZ / 1000;
  localparam int          BLINK_CNT_W  = 25;
  localparam int          SRC_COUNT    = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic       link_ok;
    logic       rx_act;
    logic       tx_act;
    logic       collision;
    logic       link_1000;
    logic       link_100;
    logic       link_10;
    logic       full_duplex;
    logic       rx_err;
    logic       tx_err;
  } plcfg_phy_status_t;

  typedef struct packed {
    logic       quick_negotiation_enable;
    logic [1:0] quick_negotiation_timer_select;
    logic       parallel_detect_full_duplex_enable;
    logic       clear_status_pulse;
    logic       robust_crossover_enable;
    logic       quick_crossover_enable;
    logic       gigabit_only_negotiation_enable;
  } plcfg_phy_ctrl_t;

endpackage : plcfg_pkg

/* File: src/plcfg_top.sv */
/*
  Indicator and general configuration register bank with AHB-Lite slave,
  indicator source mux, stretching, blink, force and polarity logic.
  Assumes a single 50 MHz clock; status and diag inputs synchronous to it.
*/
`timescale 1ns/1ps
module plcfg_top #(
  parameter int BLINK_UNIT = plcfg_pkg::CYC_PER_MS
) (
  input  wire logic                         hclk,
  input  wire logic                         hresetn,
  input  wire logic                         hsel,
  input  wire logic [31:0]                  haddr,
  input  wire logic [1:0]                   htrans,
  input  wire logic                         hwrite,
  input  wire logic [2:0]                   hsize,
  input  wire logic [31:0]                  hwdata,
  input  wire logic                         hready,
  output logic      [31:0]                  hrdata,
  output logic                              hreadyout,
  output logic                              hresp,
  input  wire plcfg_pkg::plcfg_phy_status_t phy_status,
  output plcfg_pkg::plcfg_phy_ctrl_t        phy_ctrl,
  input  wire logic                         irq_event,
  input  wire logic                         irq_or_powerdown_pin_i,
  output logic                              irq_or_powerdown_pin_o,
  output logic                              irq_or_powerdown_pin_oe,
  output logic                              powerdown_request,
  input  wire logic                         cable_diag_complete,
  input  wire logic                         cable_diag_result_fail,
  output logic                              cable_diag_run,
  output logic      [3:0]                   indicator_out
);

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave, zero wait states
  logic                              wr_pend_q;
  logic [plcfg_pkg::ADDR_W-1:0]      wr_addr_q;
  logic [15:0]                       ind_ctrl_q;
  logic [15:0]                       blink_cfg_q;
  logic [15:0]                       gen_cfg_q;
  logic [15:0]                       src_sel_q;
  logic                              diag_fail_q;
  logic                              diag_done_q;
  logic                              diag_start_q;
  logic                              clr_pulse_q;
  logic                              access;

  function automatic logic hit(input logic [plcfg_pkg::ADDR_W-1:0] a, input logic [7:0] idx);
    hit = (a == {idx, 2'b00});
  endfunction

  assign access    = hsel & hready & htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
    end else begin
      wr_pend_q <= access & hwrite;
      if (access) begin
        wr_addr_q <= haddr[plcfg_pkg::ADDR_W-1:0];
      end
    end
  end

  // Reads answer in the data phase from the registered address
  logic                         rd_pend_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_pend_q <= 1'b0;
    end else begin
      rd_pend_q <= access & ~hwrite;
    end
  end

  always_comb begin
    hrdata = 32'h0000_0000;
    if (rd_pend_q) begin
      if (hit(wr_addr_q, plcfg_pkg::IND_CTRL_IDX)) begin
        hrdata[15:0] = ind_ctrl_q;
      end else if (hit(wr_addr_q, plcfg_pkg::BLINK_CFG_IDX)) begin
        hrdata[15:0] = blink_cfg_q;
      end else if (hit(wr_addr_q, plcfg_pkg::GENERAL_CONFIG_FOUR_IDX)) begin
        hrdata[15:0] = {gen_cfg_q[15:3], diag_fail_q, diag_done_q, diag_start_q};
      end else if (hit(wr_addr_q, plcfg_pkg::SRC_SEL_IDX)) begin
        hrdata[15:0] = src_sel_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  logic        wr_ind;
  logic        wr_blk;
  logic        wr_gen;
  logic        wr_src;
  assign wr_ind = wr_pend_q & hit(wr_addr_q, plcfg_pkg::IND_CTRL_IDX);
  assign wr_blk = wr_pend_q & hit(wr_addr_q, plcfg_pkg::BLINK_CFG_IDX);
  assign wr_gen = wr_pend_q & hit(wr_addr_q, plcfg_pkg::GENERAL_CONFIG_FOUR_IDX);
  assign wr_src = wr_pend_q & hit(wr_addr_q, plcfg_pkg::SRC_SEL_IDX);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ind_ctrl_q  <= plcfg_pkg::IND_CTRL_RST;
      blink_cfg_q <= plcfg_pkg::BLINK_CFG_RST;
      gen_cfg_q   <= plcfg_pkg::GENERAL_CONFIG_FOUR_RST & plcfg_pkg::GENERAL_CONFIG_FOUR_WMASK;
      src_sel_q   <= plcfg_pkg::SRC_SEL_RST;
    end else begin
      if (wr_ind) begin
        ind_ctrl_q <= hwdata[15:0] & plcfg_pkg::IND_CTRL_WMASK;
      end
      if (wr_blk) begin
        blink_cfg_q <= hwdata[15:0] & plcfg_pkg::BLINK_CFG_WMASK;
      end
      if (wr_gen) begin
        gen_cfg_q <= hwdata[15:0] & plcfg_pkg::GENERAL_CONFIG_FOUR_WMASK;
      end
      if (wr_src) begin
        src_sel_q <= hwdata[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cable diagnostic start/done/fail
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      diag_start_q <= 1'b0;
      diag_done_q  <= 1'b1;
      diag_fail_q  <= 1'b0;
    end else begin
      if (diag_start_q && cable_diag_complete) begin
        diag_start_q <= 1'b0;
        diag_done_q  <= 1'b1;
        diag_fail_q  <= cable_diag_result_fail;
      end else if (wr_gen && hwdata[plcfg_pkg::GC_START_BIT]) begin
        diag_start_q <= 1'b1;
        diag_done_q  <= 1'b0;
        diag_fail_q  <= 1'b0;
      end
    end
  end
  assign cable_diag_run = diag_start_q;

  // One-cycle clear of the status bits on each write with the bit set
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clr_pulse_q <= 1'b0;
    end else begin
      clr_pulse_q <= wr_gen & hwdata[plcfg_pkg::GC_CLR_STAT_BIT];
    end
  end

  always_comb begin
    phy_ctrl.quick_negotiation_enable           = gen_cfg_q[plcfg_pkg::GC_QNEG_EN_BIT];
    phy_ctrl.quick_negotiation_timer_select     = gen_cfg_q[plcfg_pkg::GC_QNEG_SEL_LSB +: 2];
    phy_ctrl.parallel_detect_full_duplex_enable = gen_cfg_q[plcfg_pkg::GC_PD_FD_BIT];
    phy_ctrl.clear_status_pulse                 = clr_pulse_q;
    phy_ctrl.robust_crossover_enable            = gen_cfg_q[plcfg_pkg::GC_ROBUST_X_BIT];
    phy_ctrl.quick_crossover_enable             = gen_cfg_q[plcfg_pkg::GC_QUICK_X_BIT];
    phy_ctrl.gigabit_only_negotiation_enable    = gen_cfg_q[plcfg_pkg::GC_GIG_NEG_BIT];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared interrupt / power-down pin, open-drain active low
  logic irq_oe_d;
  assign irq_oe_d = gen_cfg_q[plcfg_pkg::GC_INT_OE_BIT] &
                    (irq_event | gen_cfg_q[plcfg_pkg::GC_FORCE_INT_BIT]);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_or_powerdown_pin_oe <= 1'b0;
      powerdown_request       <= 1'b0;
    end else begin
      irq_or_powerdown_pin_oe <= irq_oe_d;
      // Pin is only an input while not an interrupt output
      powerdown_request <= ~gen_cfg_q[plcfg_pkg::GC_INT_OE_BIT] & ~irq_or_powerdown_pin_i;
    end
  end
  assign irq_or_powerdown_pin_o = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Blink period timer
  logic [plcfg_pkg::BLINK_CNT_W-1:0] blink_cnt_q;
  logic [plcfg_pkg::BLINK_CNT_W-1:0] blink_lim;
  logic                              blink_tick;
  logic                              blink_phase_q;

  always_comb begin
    unique case (blink_cfg_q[1:0])
      2'b00:   blink_lim = plcfg_pkg::BLINK_CNT_W'(plcfg_pkg::BLINK_MS_0 * BLINK_UNIT - 1);
      2'b01:   blink_lim = plcfg_pkg::BLINK_CNT_W'(plcfg_pkg::BLINK_MS_1 * BLINK_UNIT - 1);
      2'b10:   blink_lim = plcfg_pkg::BLINK_CNT_W'(plcfg_pkg::BLINK_MS_2 * BLINK_UNIT - 1);
      2'b11:   blink_lim = plcfg_pkg::BLINK_CNT_W'(plcfg_pkg::BLINK_MS_3 * BLINK_UNIT - 1);
    endcase
  end
  assign blink_tick = (blink_cnt_q >= blink_lim);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      blink_cnt_q   <= '0;
      blink_phase_q <= 1'b0;
    end else begin
      blink_cnt_q   <= blink_tick ? '0 : blink_cnt_q + 1'b1;
      blink_phase_q <= blink_phase_q ^ blink_tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-indicator source, stretch, force and polarity
  // Ordering 0,1,2,aux matches the four nibbles of both registers
  logic [plcfg_pkg::SRC_COUNT-1:0] src_vec;
  logic                            activity;
  assign activity = phy_status.rx_act | phy_status.tx_act;
  always_comb begin
    src_vec        = '0;
    src_vec[4'h0]  = phy_status.link_ok;
    src_vec[4'h1]  = activity;
    src_vec[4'h2]  = phy_status.tx_act;
    src_vec[4'h3]  = phy_status.rx_act;
    src_vec[4'h4]  = phy_status.collision;
    src_vec[4'h5]  = phy_status.link_1000;
    src_vec[4'h6]  = phy_status.link_100;
    src_vec[4'h7]  = phy_status.link_10;
    src_vec[4'h8]  = phy_status.link_10 | phy_status.link_100;
    src_vec[4'h9]  = phy_status.link_100 | phy_status.link_1000;
    src_vec[4'ha]  = phy_status.full_duplex;
    src_vec[4'hb]  = phy_status.link_ok & ~(activity & blink_phase_q);
    src_vec[4'hd]  = phy_status.rx_err | phy_status.tx_err;
    src_vec[4'he]  = phy_status.rx_err;
  end

  genvar gi;
  generate
    for (gi = 0; gi < plcfg_pkg::NUM_IND; gi++) begin : g_ind
      logic [3:0] sel;
      logic       raw;
      logic       held_q;
      logic       hold_q;
      logic       shown;
      logic       active;
      logic [3:0] ctl;
      assign sel = src_sel_q[gi*plcfg_pkg::IND_FIELD_W +: plcfg_pkg::IND_FIELD_W];
      assign ctl = ind_ctrl_q[gi*plcfg_pkg::IND_FIELD_W +: plcfg_pkg::IND_FIELD_W];
      assign raw = src_vec[sel];

      // Short events span the rest of this and the next blink period
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          held_q <= 1'b0;
          hold_q <= 1'b0;
        end else begin
          if (raw) begin
            held_q <= 1'b1;
            hold_q <= 1'b1;
          end else if (blink_tick) begin
            hold_q <= 1'b0;
            held_q <= hold_q;
          end
        end
      end

      assign shown  = blink_cfg_q[plcfg_pkg::BLK_BYPASS_BIT] ? raw : (raw | held_q);
      assign active = ctl[plcfg_pkg::IND_EN_OFS] ? ctl[plcfg_pkg::IND_VAL_OFS] : shown;

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          indicator_out[gi] <= 1'b0;
        end else begin
          indicator_out[gi] <= ctl[plcfg_pkg::IND_POL_OFS] ? active : ~active;
        end
      end
    end
  endgenerate

endmodule // plcfg_top
